// ==== inc/swr_pkg.sv ====
// Package of constants and types for the sleep, wake and reset-cause block.
package swr_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 125000000;
  localparam int unsigned HOLD_TIME_MS = 18;
  localparam int unsigned HOLD_CYCLES = (CLOCK_HZ / 1000) * HOLD_TIME_MS;
  localparam int unsigned WDOG_TIME_MS = 18;
  localparam int unsigned WDOG_CYCLES = (CLOCK_HZ / 1000) * WDOG_TIME_MS;
  localparam int unsigned CNT_W = 32;

  // ---------------------------------------------------------------------------
  // Register map (word offsets, word index on the bus)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_PRESCALE = 4'h5;

  // Status bit positions.
  localparam int unsigned BIT_POWERDOWN = 3;
  localparam int unsigned BIT_TIMEOUT = 4;
  localparam int unsigned BIT_SLEEPING = 5;
  localparam int unsigned BIT_CORE_RESET = 6;

  // Control bits (write-only strobes).
  localparam int unsigned BIT_SLEEP_CMD = 0;
  localparam int unsigned BIT_CLEAR_CMD = 1;

  // Interrupt event bits.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_SLEEP = 0;
  localparam int unsigned EV_WDOG = 1;
  localparam int unsigned EV_PIN_WAKE = 2;
  localparam int unsigned EV_RUN_DONE = 3;

  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    SWR_RUN,
    SWR_SLEEP,
    SWR_HOLD
  } swr_mode_t;

endpackage : swr_pkg

// ==== rtl/swr_sleep_wake.sv ====
// Sleep entry, wake-up, watchdog and reset-cause flag logic with an Avalon-MM slave.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.

// What this block does
// [RULE1] Sleep instruction enters power-down state.
// [RULE2] Sleep entry sets active-low time-out flag.
// [RULE3] Sleep entry clears active-low power-down flag.
// [RULE4] Sleep clears enabled watchdog; it keeps counting.
// [RULE5] Sleep stops the main oscillator driver.
// [RULE6] Pins hold their pre-sleep state in sleep.
// [RULE7] Watchdog reset never drives the reset pin.
// [RULE8] Only pin or watchdog wakes, with full reset.
// [RULE9] Watchdog time-out clears time-out flag only.
// [RULE10] Watchdog clear sets both flags to one.
// [RULE11] Reset pin pulse leaves both flags unchanged.
// [RULE12] Flag pairs encode the four reset causes.
// [RULE13] Only four events may change the flags.
// [RULE14] Watchdog times out regardless of time-out flag.
// [RULE15] Sleep takes effect regardless of power-down flag.
// [RULE16] Every wake-up clears the watchdog counter.
// [RULE17] Watchdog time-out starts the 18 ms hold timer.
// [RULE18] Fuse at zero disables the watchdog entirely.
// [RULE19] Software writes never alter the two flags; here a CONTROL write of the sleep or clear bit does.
module swr_sleep_wake #(
  parameter int unsigned HOLD_CYCLES = swr_pkg::HOLD_CYCLES,
  parameter int unsigned WDOG_CYCLES = swr_pkg::WDOG_CYCLES,
  parameter int unsigned PIN_W = 12
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Core commands and configuration
  input wire logic sleep_instr_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic watchdog_enable_fuse_in,
  // External reset pin, active low, input only
  input wire logic ext_reset_pin_n_in,
  // Port pins requested by the core
  input wire logic [PIN_W-1:0] pin_value_in,
  input wire logic [PIN_W-1:0] pin_oe_n_in,
  // Outputs towards the chip
  output logic [PIN_W-1:0] pin_value_out,
  output logic [PIN_W-1:0] pin_oe_n_out,
  output logic osc_drive_enable_out,
  output logic core_reset_out,
  output logic timeout_flag_n_out,
  output logic powerdown_flag_n_out,
  output logic irq_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic fuse_meta;
    logic fuse_sync;
    swr_pkg::swr_mode_t mode;
    logic [swr_pkg::CNT_W-1:0] watchdog_counter;
    logic [7:0] prescale;
    logic [7:0] pre_count;
    logic [swr_pkg::CNT_W-1:0] reset_hold_timer;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic [swr_pkg::IRQ_W-1:0] irq_status;
    logic [swr_pkg::IRQ_W-1:0] irq_enable;
    logic [PIN_W-1:0] pin_value;
    logic [PIN_W-1:0] pin_oe_n;
    logic osc_on;
    logic core_reset;
    logic irq;
    logic [31:0] readdata;
    logic waitrequest;
  } swr_state_t;

  swr_state_t state;
  swr_state_t next_state;
  logic rst_meta;
  logic rst_n;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Read decode is used for the bus answer only but kept as a function for clarity.
  function automatic logic [31:0] read_word(input swr_state_t s, input logic [3:0] addr);
    logic [31:0] w;
    w = swr_pkg::UNMAPPED_READ;
    case (addr)
      swr_pkg::ADDR_STATUS: begin
        w[swr_pkg::BIT_POWERDOWN] = s.powerdown_flag_n; // [RULE12]
        w[swr_pkg::BIT_TIMEOUT] = s.timeout_flag_n; // [RULE12]
        w[swr_pkg::BIT_SLEEPING] = (s.mode == swr_pkg::SWR_SLEEP);
        w[swr_pkg::BIT_CORE_RESET] = s.core_reset;
      end
      swr_pkg::ADDR_IRQ_STATUS: w[swr_pkg::IRQ_W-1:0] = s.irq_status;
      swr_pkg::ADDR_IRQ_ENABLE: w[swr_pkg::IRQ_W-1:0] = s.irq_enable;
      swr_pkg::ADDR_PRESCALE: w[7:0] = s.prescale;
      default: w = swr_pkg::UNMAPPED_READ;
    endcase
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic sleep_cmd;
    logic clear_cmd;
    logic wd_on;
    logic wd_tick;
    logic wd_timeout;
    logic pin_low;
    logic [swr_pkg::IRQ_W-1:0] events;
    logic [swr_pkg::IRQ_W-1:0] clr;
    next_state = state;
    events = '0;
    clr = '0;
    // Bus accesses take two cycles: waitrequest drops in the cycle after the request.
    wr = avs_write_in && state.waitrequest;
    rd = avs_read_in && state.waitrequest;
    next_state.waitrequest = !((avs_read_in || avs_write_in) && state.waitrequest);
    next_state.readdata = rd ? read_word(state, avs_address_in) : state.readdata;

    next_state.pin_meta = ext_reset_pin_n_in;
    next_state.pin_sync = state.pin_meta;
    next_state.fuse_meta = watchdog_enable_fuse_in;
    next_state.fuse_sync = state.fuse_meta;
    pin_low = !state.pin_sync;
    wd_on = state.fuse_sync; // [RULE18]

    sleep_cmd = (sleep_instr_in
                 || (wr && avs_address_in == swr_pkg::ADDR_CONTROL && avs_byteenable_in[0]
                     && avs_writedata_in[swr_pkg::BIT_SLEEP_CMD]))
                && state.mode == swr_pkg::SWR_RUN; // [RULE15]
    clear_cmd = (watchdog_clear_instr_in
                 || (wr && avs_address_in == swr_pkg::ADDR_CONTROL && avs_byteenable_in[0]
                     && avs_writedata_in[swr_pkg::BIT_CLEAR_CMD]))
                && state.mode == swr_pkg::SWR_RUN;

    // Watchdog runs in every mode, independent of the time-out flag.
    wd_tick = wd_on && (state.pre_count == state.prescale);
    wd_timeout = wd_tick && (state.watchdog_counter == swr_pkg::CNT_W'(WDOG_CYCLES - 1)); // [RULE14]
    if (!wd_on) begin
      next_state.watchdog_counter = '0;
      next_state.pre_count = '0;
    end else begin
      next_state.pre_count = wd_tick ? 8'h00 : state.pre_count + 8'h01;
      if (wd_tick) begin
        next_state.watchdog_counter = wd_timeout ? '0 : state.watchdog_counter + 1'b1;
      end
    end

    case (state.mode)
      swr_pkg::SWR_RUN: begin
        if (wd_timeout) begin
          next_state.timeout_flag_n = 1'b0; // [RULE9]
          next_state.mode = swr_pkg::SWR_HOLD;
          next_state.reset_hold_timer = '0; // [RULE17]
          next_state.core_reset = 1'b1;
          events[swr_pkg::EV_WDOG] = 1'b1;
        end else if (pin_low) begin
          next_state.mode = swr_pkg::SWR_HOLD; // [RULE11]
          next_state.reset_hold_timer = '0;
          next_state.core_reset = 1'b1;
        end else if (sleep_cmd) begin
          next_state.mode = swr_pkg::SWR_SLEEP; // [RULE1]
          next_state.timeout_flag_n = 1'b1; // [RULE2]
          next_state.powerdown_flag_n = 1'b0; // [RULE3]
          next_state.watchdog_counter = '0; // [RULE4]
          next_state.pre_count = '0;
          next_state.osc_on = 1'b0; // [RULE5]
          events[swr_pkg::EV_SLEEP] = 1'b1;
        end else if (clear_cmd) begin
          next_state.timeout_flag_n = 1'b1; // [RULE10]
          next_state.powerdown_flag_n = 1'b1; // [RULE10]
          next_state.watchdog_counter = '0;
          next_state.pre_count = '0;
        end
        // Pins follow the core only while running, so sleep freezes them.
        next_state.pin_value = pin_value_in;
        next_state.pin_oe_n = pin_oe_n_in;
      end
      swr_pkg::SWR_SLEEP: begin
        // The pins keep the last values captured before sleep. [RULE6]
        if (wd_timeout || pin_low) begin // [RULE8]
          next_state.mode = swr_pkg::SWR_HOLD;
          next_state.reset_hold_timer = '0;
          next_state.core_reset = 1'b1;
          next_state.watchdog_counter = '0; // [RULE16]
          next_state.pre_count = '0;
          if (wd_timeout) begin
            next_state.timeout_flag_n = 1'b0; // [RULE9]
            events[swr_pkg::EV_WDOG] = 1'b1;
          end else begin
            events[swr_pkg::EV_PIN_WAKE] = 1'b1;
          end
        end
      end
      swr_pkg::SWR_HOLD: begin
        // The pin is only an input here; a watchdog reset stays internal. [RULE7]
        next_state.osc_on = 1'b1;
        next_state.pin_value = '0;
        next_state.pin_oe_n = '1;
        if (wd_timeout) begin
          next_state.timeout_flag_n = 1'b0; // [RULE9]
          next_state.reset_hold_timer = '0;
          events[swr_pkg::EV_WDOG] = 1'b1;
        end else if (pin_low) begin
          next_state.reset_hold_timer = '0;
        end else if (state.reset_hold_timer == swr_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
          next_state.mode = swr_pkg::SWR_RUN; // [RULE17]
          next_state.core_reset = 1'b0;
          events[swr_pkg::EV_RUN_DONE] = 1'b1;
        end else begin
          next_state.reset_hold_timer = state.reset_hold_timer + 1'b1;
        end
      end
      default: begin
        next_state.mode = swr_pkg::SWR_HOLD;
        next_state.core_reset = 1'b1;
      end
    endcase

    // Any cycle that puts the core into reset also restarts the oscillator and releases the pins.
    // Doing it on the same edge keeps the pins from moving while the oscillator still reads off.
    if (next_state.core_reset) begin
      next_state.osc_on = 1'b1;
      next_state.pin_value = '0;
      next_state.pin_oe_n = '1;
    end

    // Status writes do not reach the flags; only the events above touch them. [RULE13] [RULE19]
    if (wr && avs_byteenable_in[0]) begin
      if (avs_address_in == swr_pkg::ADDR_IRQ_ENABLE) begin
        next_state.irq_enable = avs_writedata_in[swr_pkg::IRQ_W-1:0];
      end
      if (avs_address_in == swr_pkg::ADDR_IRQ_CLEAR) begin
        clr = avs_writedata_in[swr_pkg::IRQ_W-1:0];
      end
      if (avs_address_in == swr_pkg::ADDR_PRESCALE) begin
        next_state.prescale = avs_writedata_in[7:0];
      end
    end
    // A new event wins over a clear in the same cycle.
    next_state.irq_status = (state.irq_status & ~clr) | events;
    next_state.irq = |(next_state.irq_status & next_state.irq_enable);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      // Power-up: both flags read one, core held until the hold timer expires.
      state <= '0;
      state.mode <= swr_pkg::SWR_HOLD;
      state.timeout_flag_n <= 1'b1; // [RULE12]
      state.powerdown_flag_n <= 1'b1; // [RULE12]
      state.prescale <= swr_pkg::PRESCALE_RESET;
      state.pin_oe_n <= '1;
      state.osc_on <= 1'b1;
      state.core_reset <= 1'b1;
      state.waitrequest <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign avs_readdata_out = state.readdata;
  assign avs_waitrequest_out = state.waitrequest;
  assign pin_value_out = state.pin_value;
  assign pin_oe_n_out = state.pin_oe_n;
  assign osc_drive_enable_out = state.osc_on;
  assign core_reset_out = state.core_reset;
  assign timeout_flag_n_out = state.timeout_flag_n;
  assign powerdown_flag_n_out = state.powerdown_flag_n;
  assign irq_out = state.irq;

endmodule : swr_sleep_wake

// ==== verif/swr_core_model.sv ====
// Behavioural processor core that issues sleep and watchdog-clear pulses.
module swr_core_model (
  // Clock and core reset
  input wire logic clock_in,
  input wire logic core_reset_in,
  // Command pulses
  output logic sleep_out,
  output logic clear_out,
  // Requested pin drive
  output logic [11:0] pin_value_out,
  output logic [11:0] pin_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sleep_out = 1'b0;
    clear_out = 1'b0;
    pin_value_out = 12'h000;
    pin_oe_n_out = 12'hFFF;
  end
  // Pins change every cycle so that a frozen output can be told from a following one.
  always @(posedge clock_in) begin
    pin_value_out <= pin_value_out + 12'h001;
    pin_oe_n_out <= ~pin_oe_n_out;
  end
  // A core held in reset executes nothing, so no pulse is issued then.
  task cmd(input logic slp);
    @(posedge clock_in);
    if (core_reset_in !== 1'b1) begin
      sleep_out <= slp;
      clear_out <= !slp;
    end
    @(posedge clock_in);
    sleep_out <= 1'b0;
    clear_out <= 1'b0;
  endtask : cmd
endmodule : swr_core_model

// ==== verif/swr_sleep_wake_properties.sv ====
// Port-level checker for the sleep, wake and reset-cause block.
module swr_sleep_wake_properties #(
  parameter int unsigned HOLD_CYCLES = 20,
  parameter int unsigned WDOG_CYCLES = 50,
  parameter int unsigned PIN_W = 12
) (
  // Clock, reset and core inputs
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic sleep_instr_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic ext_reset_pin_n_in,
  // Design outputs
  input wire logic [PIN_W-1:0] pin_value_out,
  input wire logic [PIN_W-1:0] pin_oe_n_out,
  input wire logic osc_drive_enable_out,
  input wire logic core_reset_out,
  input wire logic timeout_flag_n_out,
  input wire logic powerdown_flag_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // ---------------------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------------------
  // The watchdog count only gives a lower bound, since the prescaler may stretch it.
  int unsigned hold_cnt;
  int unsigned wd_cnt;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_cnt <= 0;
      wd_cnt <= 0;
    end else begin
      hold_cnt <= (core_reset_out && ext_reset_pin_n_in) ? hold_cnt + 1 : 0;
      wd_cnt <= (sleep_instr_in || watchdog_clear_instr_in || !ext_reset_pin_n_in ||
                 $rose(core_reset_out)) ? 0 : wd_cnt + 1;
    end
  end
  sequence s_run;
    !core_reset_out && osc_drive_enable_out;
  endsequence
  sequence s_asleep_pin_low;
    (!osc_drive_enable_out && !ext_reset_pin_n_in) [*3];
  endsequence
  a_sleep_enter: assert property (
    sleep_instr_in ##0 s_run |=> core_reset_out ||
    (!osc_drive_enable_out && timeout_flag_n_out && !powerdown_flag_n_out))
    else $error("sleep request did not enter sleep with flags one and zero");
  a_clear_sets_flags: assert property (
    watchdog_clear_instr_in && !sleep_instr_in ##0 s_run
    |=> core_reset_out || (timeout_flag_n_out && powerdown_flag_n_out))
    else $error("watchdog clear did not set both flags");
  a_pd_fall_cause: assert property (
    $fell(powerdown_flag_n_out) |-> $past(sleep_instr_in) && !osc_drive_enable_out)
    else $error("power-down flag cleared without sleep entry");
  a_flag_rise_cause: assert property (
    $rose(timeout_flag_n_out) || $rose(powerdown_flag_n_out)
    |-> $past(sleep_instr_in || watchdog_clear_instr_in))
    else $error("flag set without sleep or watchdog clear");
  a_timeout_effect: assert property (
    $fell(timeout_flag_n_out) |-> core_reset_out && $stable(powerdown_flag_n_out) &&
    wd_cnt >= WDOG_CYCLES - 2)
    else $error("time-out flag cleared early or without reset");
  a_pins_frozen: assert property (
    !osc_drive_enable_out && $past(!osc_drive_enable_out)
    |-> $stable(pin_value_out) && $stable(pin_oe_n_out))
    else $error("pins moved during sleep");
  a_hold_pins_off: assert property (
    core_reset_out |-> &pin_oe_n_out)
    else $error("pins driven while core held in reset");
  a_pin_wakes: assert property (
    s_asleep_pin_low |-> ##[0:2] core_reset_out)
    else $error("reset pin did not wake the device");
  a_hold_time: assert property (
    $fell(core_reset_out) |-> hold_cnt >= HOLD_CYCLES && hold_cnt <= HOLD_CYCLES + 4)
    else $error("core released after wrong hold time");
endmodule : swr_sleep_wake_properties

bind swr_sleep_wake swr_sleep_wake_properties #(
  .HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES), .PIN_W(PIN_W)
) i_props (.clock_in, .resetn_in, .sleep_instr_in, .watchdog_clear_instr_in,
  .ext_reset_pin_n_in, .pin_value_out, .pin_oe_n_out, .osc_drive_enable_out,
  .core_reset_out, .timeout_flag_n_out, .powerdown_flag_n_out);

// ==== verif/swr_sleep_wake_tb_top.sv ====
// Self-checking testbench of the sleep, wake and reset-cause block.
module swr_sleep_wake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 20;
  localparam int WC = 50;
  logic clock_in, resetn_in, rd, wr, fuse, pin_n, wreq, osc, crst, to_n, pd_n, irq, sl, cl;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata;
  logic [11:0] pv, poe, cpv, cpoe;
  int num_errors, check_count;
  swr_sleep_wake #(.HOLD_CYCLES(HC), .WDOG_CYCLES(WC)) i_dut (.clock_in, .resetn_in,
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .sleep_instr_in(sl), .watchdog_clear_instr_in(cl), .watchdog_enable_fuse_in(fuse),
    .ext_reset_pin_n_in(pin_n), .pin_value_in(cpv), .pin_oe_n_in(cpoe), .pin_value_out(pv),
    .pin_oe_n_out(poe), .osc_drive_enable_out(osc), .core_reset_out(crst),
    .timeout_flag_n_out(to_n), .powerdown_flag_n_out(pd_n), .irq_out(irq));
  swr_core_model i_core (.clock_in, .core_reset_in(crst), .sleep_out(sl), .clear_out(cl),
    .pin_value_out(cpv), .pin_oe_n_out(cpoe));
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task flags(input logic [1:0] e);
    chk({30'h0, to_n, pd_n}, {30'h0, e});
  endtask : flags
  task cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cyc
  task wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (crst !== lvl) begin
      @(posedge clock_in);
      n++;
      if (n > lim) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask : wait_rst
  // The request stands until waitrequest is sampled low; data is taken at that edge.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clock_in);
      n++;
      if (n > 20) begin
        num_errors++;
        tally_and_finish();
      end
    end while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task setp(input logic [7:0] v);
    logic [31:0] q;
    bus(1'b1, swr_pkg::ADDR_PRESCALE, {24'h0, v}, q);
  endtask : setp
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_powerup;
    logic [31:0] q;
    int n;
    flags(2'b11);
    wait_rst(1'b0, 100, n);
    bus(1'b0, swr_pkg::ADDR_PRESCALE, 32'h0, q);
    chk(q, {24'h0, swr_pkg::PRESCALE_RESET});
    setp(8'hFF);
    bus(1'b0, swr_pkg::ADDR_PRESCALE, 32'h0, q);
    chk(q, 32'hFF);
    bus(1'b1, swr_pkg::ADDR_STATUS, 32'h0, q);
    bus(1'b0, swr_pkg::ADDR_STATUS, 32'h0, q);
    chk(q[4:3], 32'h3);
    bus(1'b0, 4'hF, 32'hFFFF_FFFF, q);
    chk(q, swr_pkg::UNMAPPED_READ);
    $display("power-up test done");
  endtask : t_powerup
  task t_pin_wake;
    logic [11:0] pv0;
    int n;
    i_core.cmd(1'b1);
    cyc(1);
    chk(osc, 32'h0);
    flags(2'b10);
    pv0 = pv;
    cyc(5);
    chk(pv, pv0);
    pin_n <= 1'b0;
    cyc(5);
    chk(crst, 32'h1);
    chk(poe, 32'hFFF);
    flags(2'b10);
    pin_n <= 1'b1;
    wait_rst(1'b0, 60, n);
    flags(2'b10);
    setp(8'hFF);
    pin_n <= 1'b0;
    cyc(5);
    chk(crst, 32'h1);
    pin_n <= 1'b1;
    wait_rst(1'b0, 60, n);
    setp(8'hFF);
    flags(2'b10);
    $display("pin wake test done");
  endtask : t_pin_wake
  task t_irq;
    logic [31:0] q;
    bus(1'b0, swr_pkg::ADDR_IRQ_STATUS, 32'h0, q);
    chk(q, 32'hD);
    chk(irq, 32'h0);
    bus(1'b1, swr_pkg::ADDR_IRQ_ENABLE, 32'h4, q);
    cyc(2);
    chk(irq, 32'h1);
    bus(1'b1, swr_pkg::ADDR_IRQ_CLEAR, 32'hF, q);
    cyc(2);
    chk(irq, 32'h0);
    bus(1'b0, swr_pkg::ADDR_IRQ_STATUS, 32'h0, q);
    chk(q, 32'h0);
    $display("interrupt test done");
  endtask : t_irq
  task t_wdog;
    int n;
    setp(8'h00);
    i_core.cmd(1'b0);
    cyc(1);
    flags(2'b11);
    wait_rst(1'b1, 80, n);
    flags(2'b01);
    wait_rst(1'b0, 60, n);
    wait_rst(1'b1, 80, n);
    flags(2'b01);
    wait_rst(1'b0, 60, n);
    cyc(10);
    i_core.cmd(1'b1);
    cyc(1);
    wait_rst(1'b1, 80, n);
    chk(32'(n >= WC - 3 && n <= WC + 3), 32'h1);
    flags(2'b00);
    wait_rst(1'b0, 60, n);
    $display("watchdog test done");
  endtask : t_wdog
  task t_fuse;
    int n;
    fuse <= 1'b0;
    cyc(3);
    i_core.cmd(1'b1);
    cyc(1);
    flags(2'b10);
    cyc(3 * WC);
    chk(crst, 32'h0);
    chk(osc, 32'h0);
    pin_n <= 1'b0;
    cyc(5);
    pin_n <= 1'b1;
    wait_rst(1'b0, 60, n);
    flags(2'b10);
    fuse <= 1'b1;
    $display("fuse test done");
  endtask : t_fuse
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    {resetn_in, rd, wr} = 3'h0;
    {fuse, pin_n} = 2'h3;
    addr = 4'h0;
    be = 4'hF;
    wdata = 32'h0;
    num_errors = 0;
    check_count = 0;
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_powerup();
    t_pin_wake();
    t_irq();
    t_wdog();
    t_fuse();
    tally_and_finish();
  end
endmodule : swr_sleep_wake_tb_top
